//--- hw/iopm_pkg.sv
package iopm_pkg;

   // ****************************************
   // port indices
   // ****************************************
   localparam int NPORT = 11;
   localparam int P3 = 0;
   localparam int P4 = 1;
   localparam int P5 = 2;
   localparam int P8 = 3;
   localparam int PA = 4;
   localparam int PB = 5;
   localparam int PC = 6;
   localparam int PD = 7;
   localparam int PE = 8;
   localparam int PF = 9;
   localparam int PG = 10;

   // ****************************************
   // operating modes
   // ****************************************
   typedef enum logic [1:0] {
      MODE4 = 2'b00,
      MODE5 = 2'b01,
      MODE6 = 2'b10,
      MODE7 = 2'b11
   } iopm_mode_t;

   // ****************************************
   // per-port capability masks, port PG in the top byte
   // ****************************************
   localparam logic [NPORT*8-1:0] OUT_MASK =
      {8'h1F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'h0F, 8'h00, 8'h3F};
   localparam logic [NPORT*8-1:0] PULL_MASK =
      {8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
   localparam logic [NPORT*8-1:0] OD_MASK =
      {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h3F};

   // ****************************************
   // reset values and pin positions
   // ****************************************
   localparam logic [7:0] DIR_RST = 8'h00;
   localparam logic [7:0] LATCH_RST = 8'h00;
   localparam logic [7:0] PULL_RST = 8'h00;
   localparam logic [7:0] OD_RST = 8'h00;
   localparam int PF_CLK = 7;
   localparam int PF_AS = 6;
   localparam int PF_RD = 5;
   localparam int PF_HWS = 4;
   localparam int PF_LWS = 3;
   localparam int PF_LCS = 2;
   localparam int PF_BRQ = 1;
   localparam int PF_GRANT = 0;
   localparam int P5_WAIT = 3;
   localparam int P8_WAIT = 6;
   localparam logic [2:0] DRAM_SEL_LO = 3'h1;
   localparam logic [2:0] DRAM_SEL_HI = 3'h3;

endpackage

//--- hw/iopm_port.sv
`timescale 1ns/100ps
`default_nettype none
module iopm_port
#(
   parameter logic [7:0] OUT_MASK = 8'hFF,
   parameter logic [7:0] PULL_MASK = 8'h00,
   parameter logic [7:0] OD_MASK = 8'h00
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // register access
   input wire logic [7:0] dirRst,
   input wire logic wrDir,
   input wire logic wrLatch,
   input wire logic wrPull,
   input wire logic wrOdc,
   input wire logic [7:0] wrData,
   output logic [7:0] readBack,
   // pin side
   input wire logic [7:0] pinIn,
   output logic [7:0] pinSync,
   output logic [7:0] dir,
   output logic [7:0] latch,
   output logic [7:0] odc,
   output logic [7:0] pullupOn
);

   if ((OD_MASK & ~OUT_MASK) != 8'h00)
   begin : g_chk
      $error("open-drain bits must be output-capable");
   end

   logic [7:0] dir_r, dir_nxt;
   logic [7:0] latch_r, latch_nxt;
   logic [7:0] pull_r, pull_nxt;
   logic [7:0] odc_r, odc_nxt;
   logic [7:0] meta_r, meta_nxt;
   logic [7:0] sync_r, sync_nxt;

   always_comb
   begin
      dir_nxt = dir_r;
      latch_nxt = latch_r;
      pull_nxt = pull_r;
      odc_nxt = odc_r;
      // input-only bits never get a direction bit
      if (wrDir)
         dir_nxt = wrData & OUT_MASK;
      if (wrLatch)
         latch_nxt = wrData;
      if (wrPull)
         pull_nxt = wrData & PULL_MASK;
      if (wrOdc)
         odc_nxt = wrData & OD_MASK;
      meta_nxt = pinIn;
      sync_nxt = meta_r;
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         dir_r <= dirRst & OUT_MASK;
         latch_r <= iopm_pkg::LATCH_RST;
         pull_r <= iopm_pkg::PULL_RST;
         odc_r <= iopm_pkg::OD_RST;
         meta_r <= 8'h00;
         sync_r <= 8'h00;
      end
      else
      begin
         dir_r <= dir_nxt;
         latch_r <= latch_nxt;
         pull_r <= pull_nxt;
         odc_r <= odc_nxt;
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
      end
   end

   assign readBack = (dir_r & latch_r) | (~dir_r & sync_r);
   // pull-up only matters while the pin is not driven
   assign pullupOn = pull_r & ~dir_r;
   assign pinSync = sync_r;
   assign dir = dir_r;
   assign latch = latch_r;
   assign odc = odc_r;

endmodule
`default_nettype wire

//--- hw/iopm_mux.sv
// Function
// - bidirectional ports have per-pin direction bits; input-only ports have none.
// - each port has an output latch; it drives general-purpose output pins on every port but port 4.
// - each port has a read-only readback of the latch or pin levels.
// - port 4 and port 5 upper nibble are inputs only.
// - ports A to E have per-pin input pull-up enables.
// - port 3 and port A have open-drain controls disabling the high-side driver.
// - PF7 outputs system clock when direction is 1; reset direction depends on mode.
// - PF6 outputs address strobe unless its pin disable bit is set.
// - PF3 outputs low write strobe unless its pin disable bit is set.
// - PF2 drives bus-request drop when its enable is set and pin select is 0.
// - PF2 drives lower column strobe for DRAM select 1..3 with 16-bit space.
// - PF1 becomes bus request input when bus release enabled; grant output too.
// - P53 is wait input under wait enable, select 1, no drop output, direction 0.
// - P53 drives bus-request drop when selected there; feeds interrupt 7 if alt set.
// - P50..P52 carry serial channel 2, and interrupts 4..6 when alt set.
// - P86 is wait input when wait select is 0 and direction is 0.
// - PG3 is input, port output, or chip select 1 by direction and enable.
// - PG2 and PG1 likewise give chip selects 2 and 3.
// - PG0 drives column strobe when DRAM space configured, else general I/O.
// - port A upper pins output address when direction and enable are 1.
// - port E carries low data byte in 16-bit bus mode only.
// - in mode 6, ports B, C and port A lower nibble output address bits when direction is 1.
// - direction 1 makes a pin output, 0 makes it input.
// - readback returns latch for output bits, pin level for input bits.
`timescale 1ns/100ps
`default_nettype none
module iopm_mux
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // operating mode and bus setup
   input wire logic [1:0] opMode,
   input wire logic busWidth16,
   input wire logic [2:0] dramSpaceSel,
   input wire logic dramSpace16,
   // pin function controls
   input wire logic strobePinDisable,
   input wire logic lowWritePinDisable,
   input wire logic busreqDropOutEn,
   input wire logic busreqDropPinSel,
   input wire logic busReleaseEn,
   input wire logic waitPinEn,
   input wire logic waitPinSel,
   input wire logic irqAltPinSel,
   input wire logic chipsel1En,
   input wire logic chipsel23En,
   input wire logic [3:0] upperAddrEn,
   // port register access, one strobe bit per port
   input wire logic [iopm_pkg::NPORT-1:0] wrDir,
   input wire logic [iopm_pkg::NPORT-1:0] wrLatch,
   input wire logic [iopm_pkg::NPORT-1:0] wrPullup,
   input wire logic [iopm_pkg::NPORT-1:0] wrOpendrain,
   input wire logic [7:0] wrData,
   output logic [iopm_pkg::NPORT*8-1:0] portRead,
   // package pins
   input wire logic [iopm_pkg::NPORT*8-1:0] pinIn,
   output logic [iopm_pkg::NPORT*8-1:0] pinOut,
   output logic [iopm_pkg::NPORT*8-1:0] pinOe,
   output logic [iopm_pkg::NPORT*8-1:0] pullupOn,
   // bus controller outputs
   input wire logic [23:0] addr,
   input wire logic [15:0] busDataOut,
   input wire logic busDataOe,
   input wire logic sysClkLevel,
   input wire logic addrStrobeN,
   input wire logic readStrobeN,
   input wire logic highWriteStrobeN,
   input wire logic lowWriteStrobeN,
   input wire logic lowerColStrobeN,
   input wire logic colStrobeN,
   input wire logic [3:0] chipSelN,
   input wire logic busreqDropOutN,
   input wire logic extBusGrantN,
   // bus controller inputs
   output logic [15:0] busDataIn,
   output logic waitN,
   output logic extBusRequestN,
   // serial channel 2 and interrupts
   input wire logic sciTx,
   input wire logic sciTxOe,
   input wire logic sciClkOut,
   input wire logic sciClkOe,
   output logic sciRx,
   output logic sciClkIn,
   output logic [3:0] irqAltN,
   output logic adcExtTriggerN
);

   localparam int NP = iopm_pkg::NPORT;

   // ****************************************
   // port slices
   // ****************************************
   logic [NP*8-1:0] dirAll;
   logic [NP*8-1:0] latchAll;
   logic [NP*8-1:0] odcAll;
   logic [NP*8-1:0] syncAll;
   logic modeLow;
   logic [7:0] pfDirRst;

   // in modes 4 and 5 the clock pin comes out of reset as an output
   assign modeLow = (opMode == iopm_pkg::MODE4) || (opMode == iopm_pkg::MODE5);
   assign pfDirRst = {modeLow, 7'h00};

   for (genvar p = 0; p < NP; p++)
   begin : g_port
      iopm_port
      #(
         .OUT_MASK(iopm_pkg::OUT_MASK[p*8 +: 8]),
         .PULL_MASK(iopm_pkg::PULL_MASK[p*8 +: 8]),
         .OD_MASK(iopm_pkg::OD_MASK[p*8 +: 8])
      )
      u_port
      (
         .ref_clk(ref_clk),
         .reset(reset),
         .dirRst((p == iopm_pkg::PF) ? pfDirRst : iopm_pkg::DIR_RST),
         .wrDir(wrDir[p]),
         .wrLatch(wrLatch[p]),
         .wrPull(wrPullup[p]),
         .wrOdc(wrOpendrain[p]),
         .wrData(wrData),
         .readBack(portRead[p*8 +: 8]),
         .pinIn(pinIn[p*8 +: 8]),
         .pinSync(syncAll[p*8 +: 8]),
         .dir(dirAll[p*8 +: 8]),
         .latch(latchAll[p*8 +: 8]),
         .odc(odcAll[p*8 +: 8]),
         .pullupOn(pullupOn[p*8 +: 8])
      );
   end

   function automatic int pi(input int port, input int pos);
      pi = port * 8 + pos;
   endfunction

   // ****************************************
   // alternate function selection
   // ****************************************
   logic [NP*8-1:0] altSel;
   logic [NP*8-1:0] altOe;
   logic [NP*8-1:0] altOut;
   logic extMode;
   logic mode6;
   logic dramLower;
   logic p5Wait;
   logic p8Wait;

   assign extMode = opMode != iopm_pkg::MODE7;
   assign mode6 = opMode == iopm_pkg::MODE6;
   assign dramLower = (dramSpaceSel >= iopm_pkg::DRAM_SEL_LO) && (dramSpaceSel <= iopm_pkg::DRAM_SEL_HI)
      && dramSpace16;
   assign p5Wait = extMode && waitPinEn && !busreqDropOutEn && waitPinSel
      && !dirAll[pi(iopm_pkg::P5, iopm_pkg::P5_WAIT)];
   assign p8Wait = extMode && !waitPinSel && !dirAll[pi(iopm_pkg::P8, iopm_pkg::P8_WAIT)];

   always_comb
   begin
      altSel = '0;
      altOe = '0;
      altOut = '0;
      for (int b = 0; b < 8; b++)
      begin
         // port A: low nibble tracks modes, high nibble also needs its enable
         if (b < 4)
         begin
            if (modeLow || (mode6 && dirAll[pi(iopm_pkg::PA, b)]))
            begin
               altSel[pi(iopm_pkg::PA, b)] = 1'b1;
               altOe[pi(iopm_pkg::PA, b)] = 1'b1;
               altOut[pi(iopm_pkg::PA, b)] = addr[16 + b];
            end
         end
         else if (extMode && dirAll[pi(iopm_pkg::PA, b)] && upperAddrEn[b - 4])
         begin
            altSel[pi(iopm_pkg::PA, b)] = 1'b1;
            altOe[pi(iopm_pkg::PA, b)] = 1'b1;
            altOut[pi(iopm_pkg::PA, b)] = addr[16 + b];
         end
         if (modeLow || (mode6 && dirAll[pi(iopm_pkg::PB, b)]))
         begin
            altSel[pi(iopm_pkg::PB, b)] = 1'b1;
            altOe[pi(iopm_pkg::PB, b)] = 1'b1;
            altOut[pi(iopm_pkg::PB, b)] = addr[8 + b];
         end
         if (modeLow || (mode6 && dirAll[pi(iopm_pkg::PC, b)]))
         begin
            altSel[pi(iopm_pkg::PC, b)] = 1'b1;
            altOe[pi(iopm_pkg::PC, b)] = 1'b1;
            altOut[pi(iopm_pkg::PC, b)] = addr[b];
         end
         // data bus: upper byte always in external modes, lower byte only when 16 bits wide
         if (extMode)
         begin
            altSel[pi(iopm_pkg::PD, b)] = 1'b1;
            altOe[pi(iopm_pkg::PD, b)] = busDataOe;
            altOut[pi(iopm_pkg::PD, b)] = busDataOut[8 + b];
         end
         if (extMode && busWidth16)
         begin
            altSel[pi(iopm_pkg::PE, b)] = 1'b1;
            altOe[pi(iopm_pkg::PE, b)] = busDataOe;
            altOut[pi(iopm_pkg::PE, b)] = busDataOut[b];
         end
      end

      // ---- port F ----
      if (dirAll[pi(iopm_pkg::PF, iopm_pkg::PF_CLK)])
      begin
         altSel[pi(iopm_pkg::PF, iopm_pkg::PF_CLK)] = 1'b1;
         altOe[pi(iopm_pkg::PF, iopm_pkg::PF_CLK)] = 1'b1;
         altOut[pi(iopm_pkg::PF, iopm_pkg::PF_CLK)] = sysClkLevel;
      end
      if (extMode && !strobePinDisable)
      begin
         altSel[pi(iopm_pkg::PF, iopm_pkg::PF_AS)] = 1'b1;
         altOe[pi(iopm_pkg::PF, iopm_pkg::PF_AS)] = 1'b1;
         altOut[pi(iopm_pkg::PF, iopm_pkg::PF_AS)] = addrStrobeN;
      end
      if (extMode)
      begin
         altSel[pi(iopm_pkg::PF, iopm_pkg::PF_RD)] = 1'b1;
         altOe[pi(iopm_pkg::PF, iopm_pkg::PF_RD)] = 1'b1;
         altOut[pi(iopm_pkg::PF, iopm_pkg::PF_RD)] = readStrobeN;
         altSel[pi(iopm_pkg::PF, iopm_pkg::PF_HWS)] = 1'b1;
         altOe[pi(iopm_pkg::PF, iopm_pkg::PF_HWS)] = 1'b1;
         altOut[pi(iopm_pkg::PF, iopm_pkg::PF_HWS)] = highWriteStrobeN;
      end
      if (extMode && !lowWritePinDisable)
      begin
         altSel[pi(iopm_pkg::PF, iopm_pkg::PF_LWS)] = 1'b1;
         altOe[pi(iopm_pkg::PF, iopm_pkg::PF_LWS)] = 1'b1;
         altOut[pi(iopm_pkg::PF, iopm_pkg::PF_LWS)] = lowWriteStrobeN;
      end
      // the DRAM strobe wins the shared pin over the request-drop output
      if (extMode && dramLower)
      begin
         altSel[pi(iopm_pkg::PF, iopm_pkg::PF_LCS)] = 1'b1;
         altOe[pi(iopm_pkg::PF, iopm_pkg::PF_LCS)] = 1'b1;
         altOut[pi(iopm_pkg::PF, iopm_pkg::PF_LCS)] = lowerColStrobeN;
      end
      else if (extMode && busreqDropOutEn && !busreqDropPinSel)
      begin
         altSel[pi(iopm_pkg::PF, iopm_pkg::PF_LCS)] = 1'b1;
         altOe[pi(iopm_pkg::PF, iopm_pkg::PF_LCS)] = 1'b1;
         altOut[pi(iopm_pkg::PF, iopm_pkg::PF_LCS)] = busreqDropOutN;
      end
      if (extMode && busReleaseEn)
      begin
         altSel[pi(iopm_pkg::PF, iopm_pkg::PF_BRQ)] = 1'b1;
         altSel[pi(iopm_pkg::PF, iopm_pkg::PF_GRANT)] = 1'b1;
         altOe[pi(iopm_pkg::PF, iopm_pkg::PF_GRANT)] = 1'b1;
         altOut[pi(iopm_pkg::PF, iopm_pkg::PF_GRANT)] = extBusGrantN;
      end

      // ---- port G ----
      if (modeLow && dirAll[pi(iopm_pkg::PG, 4)])
      begin
         altSel[pi(iopm_pkg::PG, 4)] = 1'b1;
         altOe[pi(iopm_pkg::PG, 4)] = 1'b1;
         altOut[pi(iopm_pkg::PG, 4)] = chipSelN[0];
      end
      if (extMode && chipsel1En && dirAll[pi(iopm_pkg::PG, 3)])
      begin
         altSel[pi(iopm_pkg::PG, 3)] = 1'b1;
         altOe[pi(iopm_pkg::PG, 3)] = 1'b1;
         altOut[pi(iopm_pkg::PG, 3)] = chipSelN[1];
      end
      for (int c = 1; c < 3; c++)
      begin
         if (extMode && chipsel23En && dirAll[pi(iopm_pkg::PG, 3 - c)])
         begin
            altSel[pi(iopm_pkg::PG, 3 - c)] = 1'b1;
            altOe[pi(iopm_pkg::PG, 3 - c)] = 1'b1;
            altOut[pi(iopm_pkg::PG, 3 - c)] = chipSelN[1 + c];
         end
      end
      if (extMode && (dramSpaceSel != 3'h0))
      begin
         altSel[pi(iopm_pkg::PG, 0)] = 1'b1;
         altOe[pi(iopm_pkg::PG, 0)] = 1'b1;
         altOut[pi(iopm_pkg::PG, 0)] = colStrobeN;
      end

      // ---- port 5 and port 8 ----
      if (sciTxOe)
      begin
         altSel[pi(iopm_pkg::P5, 0)] = 1'b1;
         altOe[pi(iopm_pkg::P5, 0)] = 1'b1;
         altOut[pi(iopm_pkg::P5, 0)] = sciTx;
      end
      if (sciClkOe)
      begin
         altSel[pi(iopm_pkg::P5, 2)] = 1'b1;
         altOe[pi(iopm_pkg::P5, 2)] = 1'b1;
         altOut[pi(iopm_pkg::P5, 2)] = sciClkOut;
      end
      if (p5Wait)
         altSel[pi(iopm_pkg::P5, iopm_pkg::P5_WAIT)] = 1'b1;
      else if (extMode && !waitPinEn && busreqDropOutEn && busreqDropPinSel)
      begin
         altSel[pi(iopm_pkg::P5, iopm_pkg::P5_WAIT)] = 1'b1;
         altOe[pi(iopm_pkg::P5, iopm_pkg::P5_WAIT)] = 1'b1;
         altOut[pi(iopm_pkg::P5, iopm_pkg::P5_WAIT)] = busreqDropOutN;
      end
      if (p8Wait)
         altSel[pi(iopm_pkg::P8, iopm_pkg::P8_WAIT)] = 1'b1;
   end

   // ****************************************
   // pin drive and peripheral inputs
   // ****************************************
   logic [NP*8-1:0] pinOut_r, pinOut_nxt;
   logic [NP*8-1:0] pinOe_r, pinOe_nxt;
   logic [15:0] busDataIn_r, busDataIn_nxt;
   logic waitN_r, waitN_nxt;
   logic extBusRequestN_r, extBusRequestN_nxt;
   logic sciRx_r, sciRx_nxt;
   logic sciClkIn_r, sciClkIn_nxt;
   logic [3:0] irqAltN_r, irqAltN_nxt;
   logic adcTrig_r, adcTrig_nxt;

   always_comb
   begin
      pinOut_nxt = (altSel & altOut) | (~altSel & latchAll);
      pinOe_nxt = (altSel & altOe) | (~altSel & dirAll);
      // open drain: a high level is left to the external pull-up
      pinOe_nxt = pinOe_nxt & ~(odcAll & pinOut_nxt);
      busDataIn_nxt = {syncAll[pi(iopm_pkg::PD, 0) +: 8], syncAll[pi(iopm_pkg::PE, 0) +: 8]};
      if (p5Wait)
         waitN_nxt = syncAll[pi(iopm_pkg::P5, iopm_pkg::P5_WAIT)];
      else if (p8Wait)
         waitN_nxt = syncAll[pi(iopm_pkg::P8, iopm_pkg::P8_WAIT)];
      else
         waitN_nxt = 1'b1;
      extBusRequestN_nxt = (extMode && busReleaseEn) ? syncAll[pi(iopm_pkg::PF, iopm_pkg::PF_BRQ)] : 1'b1;
      sciRx_nxt = syncAll[pi(iopm_pkg::P5, 1)];
      sciClkIn_nxt = syncAll[pi(iopm_pkg::P5, 2)];
      // interrupts 4..7 idle high while the alternate pins are not selected
      irqAltN_nxt = irqAltPinSel ? syncAll[pi(iopm_pkg::P5, 0) +: 4] : 4'hF;
      adcTrig_nxt = syncAll[pi(iopm_pkg::P5, 3)];
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         pinOut_r <= '0;
         pinOe_r <= '0;
         busDataIn_r <= 16'h0000;
         waitN_r <= 1'b1;
         extBusRequestN_r <= 1'b1;
         sciRx_r <= 1'b1;
         sciClkIn_r <= 1'b1;
         irqAltN_r <= 4'hF;
         adcTrig_r <= 1'b1;
      end
      else
      begin
         pinOut_r <= pinOut_nxt;
         pinOe_r <= pinOe_nxt;
         busDataIn_r <= busDataIn_nxt;
         waitN_r <= waitN_nxt;
         extBusRequestN_r <= extBusRequestN_nxt;
         sciRx_r <= sciRx_nxt;
         sciClkIn_r <= sciClkIn_nxt;
         irqAltN_r <= irqAltN_nxt;
         adcTrig_r <= adcTrig_nxt;
      end
   end

   assign pinOut = pinOut_r;
   assign pinOe = pinOe_r;
   assign busDataIn = busDataIn_r;
   assign waitN = waitN_r;
   assign extBusRequestN = extBusRequestN_r;
   assign sciRx = sciRx_r;
   assign sciClkIn = sciClkIn_r;
   assign irqAltN = irqAltN_r;
   assign adcExtTriggerN = adcTrig_r;

endmodule
`default_nettype wire

//--- sim/iopm_mux_chk.sv
`timescale 1ns/100ps
`default_nettype none
module iopm_mux_chk
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // controls
   input wire logic [1:0] opMode,
   input wire logic busWidth16,
   input wire logic [2:0] dramSpaceSel,
   input wire logic dramSpace16,
   input wire logic strobePinDisable,
   input wire logic busReleaseEn,
   input wire logic chipsel1En,
   // bus controller
   input wire logic [23:0] addr,
   input wire logic [15:0] busDataOut,
   input wire logic busDataOe,
   input wire logic sysClkLevel,
   input wire logic addrStrobeN,
   input wire logic lowerColStrobeN,
   input wire logic [3:0] chipSelN,
   // pins
   input wire logic [87:0] pinOut,
   input wire logic [87:0] pinOe
);
   // ****************************************
   // pin function checks
   // ****************************************
   // pins lag their cause by one edge, so the edge right after reset is skipped
   logic live_r;
   always_ff @(posedge ref_clk)
   begin
      live_r <= !reset;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   AST_IN_ONLY: assert property (pinOe[15:8] == 8'h00 && pinOe[23:20] == 4'h0)
      else $error("input-only pin driven");
   AST_CLK: assert property (live_r && pinOe[79] |-> pinOut[79] == $past(sysClkLevel))
      else $error("clock pin mismatch");
   AST_AS: assert property (live_r && $past(opMode) != 2'h3 && !$past(strobePinDisable)
      |-> pinOe[78] && pinOut[78] == $past(addrStrobeN)) else $error("address strobe pin mismatch");
   AST_LCS: assert property (live_r && $past(opMode) != 2'h3 && $past(dramSpace16) && $past(dramSpaceSel) != 3'h0
      && !$past(dramSpaceSel[2]) |-> pinOe[74] && pinOut[74] == $past(lowerColStrobeN)) else $error("lower strobe");
   AST_BRQ: assert property ((busReleaseEn && opMode != 2'h3)[*2] ##0 live_r |-> !pinOe[73])
      else $error("bus request pin driven");
   AST_CS1: assert property (live_r && $past(opMode) != 2'h3 && $past(chipsel1En) && pinOe[83]
      |-> pinOut[83] == $past(chipSelN[1])) else $error("chip select 1 pin mismatch");
   AST_DATA: assert property (live_r && $past(opMode) != 2'h3 && $past(busWidth16) |-> pinOut[71:64] ==
      $past(busDataOut[7:0]) && pinOe[71:64] == {8{$past(busDataOe)}}) else $error("low data byte mismatch");
   AST_ADDR: assert property (live_r && !$past(opMode[1]) |-> pinOe[55:40] == 16'hFFFF
      && pinOut[55:40] == {$past(addr[7:0]), $past(addr[15:8])}) else $error("address pins mismatch");
endmodule
bind iopm_mux iopm_mux_chk chk_u (.*);
`default_nettype wire

//--- sim/iopm_board.sv
`timescale 1ns/100ps
`default_nettype none
module iopm_board
(
   // clock
   input wire logic ref_clk,
   // design side
   input wire logic [87:0] pinOut,
   input wire logic [87:0] pinOe,
   input wire logic [87:0] pullupOn,
   // board drivers
   input wire logic [87:0] extDrv,
   input wire logic [87:0] extOe,
   // pin levels
   output logic [87:0] pinIn
);
   // ****************************************
   // pin level resolution
   // ****************************************
   // an undriven pin without pull-up wanders, so a stale level never reads as valid
   logic [87:0] float_r = '0;
   always_ff @(posedge ref_clk)
   begin
      float_r <= ~float_r;
   end
   always_comb
   begin
      for (int i = 0; i < 88; i++)
      begin
         if (pinOe[i])
            pinIn[i] = pinOut[i];
         else if (extOe[i])
            pinIn[i] = extDrv[i];
         else if (pullupOn[i])
            pinIn[i] = 1'h1;
         else
            pinIn[i] = float_r[i];
      end
   end
endmodule
`default_nettype wire

//--- sim/io_port_pin_function_mux_tb.sv
`timescale 1ns/100ps
`default_nettype none
module io_port_pin_function_mux_tb;
   logic ref_clk = 1'h0;
   logic reset;
   logic [1:0] opMode;
   logic [2:0] dramSpaceSel;
   logic [3:0] upperAddrEn, chipSelN, irqAltN;
   logic [10:0] wrDir, wrLatch, wrPullup, wrOpendrain;
   logic [7:0] wrData;
   logic [23:0] addr;
   logic [15:0] busDataOut, busDataIn;
   logic [87:0] portRead, pinIn, pinOut, pinOe, pullupOn, extDrv, extOe;
   logic busWidth16, dramSpace16, strobePinDisable, lowWritePinDisable, busreqDropOutEn, busreqDropPinSel;
   logic busReleaseEn, waitPinEn, waitPinSel, irqAltPinSel, chipsel1En, chipsel23En, busDataOe, sysClkLevel;
   logic addrStrobeN, readStrobeN, highWriteStrobeN, lowWriteStrobeN, lowerColStrobeN, colStrobeN;
   logic busreqDropOutN, extBusGrantN, waitN, extBusRequestN, sciTx, sciTxOe, sciClkOut, sciClkOe;
   logic sciRx, sciClkIn, adcExtTriggerN;
   int failCount = 0;
   int comparisons = 0;
   iopm_mux dut_u (.*);
   iopm_board board_u (.*);
   always #5 ref_clk = ~ref_clk;
   // ****************************************
   // access tasks
   // ****************************************
   function automatic logic [7:0] pb(input logic [87:0] v, input int p);
      return v[p*8 +: 8];
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         failCount++;
         $display("unexpected %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   // k selects direction, latch, pull-up or open-drain strobe
   task automatic wr(input int k, input int p, input logic [7:0] d);
      @(negedge ref_clk);
      wrData = d;
      {wrOpendrain, wrPullup, wrLatch, wrDir} = 44'h1 << (k * 11 + p);
      @(negedge ref_clk);
      {wrOpendrain, wrPullup, wrLatch, wrDir} = '0;
   endtask
   task automatic ext(input int p, input logic [7:0] d, input logic [7:0] oe);
      extDrv[p*8 +: 8] = d;
      extOe[p*8 +: 8] = oe;
   endtask
   task automatic finalReport;
      $display("comparisons %0d mismatches %0d", comparisons, failCount);
      if (failCount == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // tests need about 70 cycles; over forty times that means a hang
   initial
   begin
      repeat (3000) @(posedge ref_clk);
      failCount++;
      finalReport;
   end
   initial
   begin
      reset = 1'h1;
      opMode = 2'h3;
      {busWidth16, dramSpace16, strobePinDisable, lowWritePinDisable, busreqDropOutEn, busreqDropPinSel} = '0;
      {busReleaseEn, waitPinEn, waitPinSel, irqAltPinSel, chipsel1En, chipsel23En, busDataOe, sysClkLevel} = '0;
      {addrStrobeN, readStrobeN, highWriteStrobeN, lowWriteStrobeN, lowerColStrobeN, colStrobeN} = '1;
      {busreqDropOutN, extBusGrantN, sciTx, sciTxOe, sciClkOut, sciClkOe} = '0;
      {wrDir, wrLatch, wrPullup, wrOpendrain} = '0;
      {wrData, dramSpaceSel, upperAddrEn, chipSelN} = '0;
      addr = 24'h5A_C396;
      busDataOut = 16'h1234;
      {extDrv, extOe} = '0;
      ext(iopm_pkg::PB, 8'hA5, 8'hFF);
      step(8);
      reset = 1'h0;
      step(4);
      chk(pb(pinOe, iopm_pkg::PF), 8'h00);
      chk(pb(portRead, iopm_pkg::PB), 8'hA5);
      $display("test reset done");
      wr(1, iopm_pkg::PB, 8'h3C);
      wr(0, iopm_pkg::PB, 8'h0F);
      wr(0, iopm_pkg::P4, 8'hFF);
      wr(0, iopm_pkg::P5, 8'hF0);
      step(2);
      chk(pb(pinOe, iopm_pkg::PB), 8'h0F);
      chk(pb(pinOut, iopm_pkg::PB) & 8'h0F, 8'h0C);
      chk(pb(portRead, iopm_pkg::PB), 8'hAC);
      chk(pb(pinOe, iopm_pkg::P4) | pb(pinOe, iopm_pkg::P5), 8'h00);
      $display("test direction done");
      wr(2, iopm_pkg::PA, 8'hFF);
      wr(2, iopm_pkg::P3, 8'hFF);
      step(1);
      chk(pb(pullupOn, iopm_pkg::PA), 8'hFF);
      chk(pb(pullupOn, iopm_pkg::P3), 8'h00);
      wr(0, iopm_pkg::PA, 8'hFF);
      wr(1, iopm_pkg::PA, 8'h0F);
      wr(3, iopm_pkg::PA, 8'hFF);
      step(2);
      chk(pb(pullupOn, iopm_pkg::PA), 8'h00);
      chk(pb(pinOe, iopm_pkg::PA), 8'hF0);
      $display("test pull-up and open drain done");
      opMode = 2'h0;
      reset = 1'h1;
      step(3);
      reset = 1'h0;
      step(2);
      chk(pb(pinOe, iopm_pkg::PF) & 8'h80, 8'h80);
      chk(pb(pinOut, iopm_pkg::PB), 8'hC3);
      wr(0, iopm_pkg::PA, 8'hFF);
      upperAddrEn = 4'hF;
      step(2);
      chk(pb(pinOut, iopm_pkg::PA), 8'h5A);
      upperAddrEn = 4'h0;
      busWidth16 = 1'h1;
      busDataOe = 1'h1;
      addrStrobeN = 1'h0;
      sysClkLevel = 1'h1;
      step(2);
      chk(pb(pinOut, iopm_pkg::PA), 8'h0A);
      chk(pb(pinOut, iopm_pkg::PE), 8'h34);
      chk(pb(pinOut, iopm_pkg::PF) & 8'hC8, 8'h88);
      busWidth16 = 1'h0;
      {strobePinDisable, lowWritePinDisable, busreqDropOutEn} = 3'h7;
      step(2);
      chk(pb(pinOe, iopm_pkg::PE), 8'h00);
      chk(pb(pinOe, iopm_pkg::PF) & 8'h48, 8'h00);
      chk(pb(pinOe & ~pinOut, iopm_pkg::PF) & 8'h04, 8'h04);
      {dramSpaceSel, dramSpace16, busReleaseEn} = 5'h07;
      ext(iopm_pkg::PF, 8'h00, 8'h02);
      step(4);
      chk(pb(pinOut, iopm_pkg::PF) & 8'h04, 8'h04);
      chk({7'h0, extBusRequestN}, 8'h00);
      chk(pb(pinOe, iopm_pkg::PF) & 8'h03, 8'h01);
      $display("test bus pins done");
      {busreqDropOutEn, waitPinEn, waitPinSel} = 3'h3;
      ext(iopm_pkg::P5, 8'h00, 8'h0E);
      step(4);
      chk({7'h0, waitN}, 8'h00);
      {waitPinEn, busreqDropOutEn, busreqDropPinSel} = 3'h3;
      step(4);
      chk(pb(pinOe & ~pinOut, iopm_pkg::P5) & 8'h08, 8'h08);
      chk({7'h0, waitN}, 8'h01);
      {busreqDropOutEn, waitPinSel, irqAltPinSel, sciTxOe} = 4'h3;
      ext(iopm_pkg::P8, 8'h00, 8'h40);
      step(4);
      chk({7'h0, waitN}, 8'h00);
      chk(busDataIn[15:8], 8'h12);
      chk({4'h0, irqAltN}, 8'h00);
      chk({6'h0, sciClkIn, sciRx}, 8'h00);
      $display("test wait and interrupt done");
      wr(0, iopm_pkg::PG, 8'h1F);
      {chipsel1En, chipsel23En, chipSelN} = 6'h3A;
      step(2);
      chk(pb(pinOut, iopm_pkg::PG) & 8'h1F, 8'h0B);
      chipsel1En = 1'h0;
      dramSpaceSel = 3'h0;
      step(2);
      chk(pb(pinOut, iopm_pkg::PG) & 8'h1F, 8'h02);
      $display("test chip selects done");
      finalReport;
   end
endmodule
`default_nettype wire
